// ===== common/pswc_cfg.svh
// Register map, field positions, codes and timing figures of the power-state controller
`ifndef PSWC_CFG_SVH
`define PSWC_CFG_SVH

// Byte addresses of the registers
`define PSWC_OFF_CTRL      8'h00
`define PSWC_OFF_PROBE     8'h04
`define PSWC_OFF_IRQ       8'h08
`define PSWC_OFF_PHY       8'h0C

// Field positions inside power_mgmt_ctrl_reg
`define PSWC_BIT_READY     0
`define PSWC_BIT_PIN_EN    1
`define PSWC_BIT_PULSE     2
`define PSWC_BIT_ENERGY    8
`define PSWC_BIT_FRAME     9
`define PSWC_BIT_WSS       12
`define PSWC_BIT_PSS       16
// Field position of the wake flag and of the energy-detect power-down bit
`define PSWC_BIT_IRQ_WAKE  0
`define PSWC_BIT_PHY_EDPD  0

// Power-state select encodings
`define PSWC_PSS_NORMAL    2'h0
`define PSWC_PSS_SLEEP1    2'h1
`define PSWC_PSS_SLEEP2    2'h2
// Wake-source status encodings
`define PSWC_WSS_NONE      2'h0
`define PSWC_WSS_ENERGY    2'h1
`define PSWC_WSS_FRAME     2'h2

// Bus answers
`define PSWC_RESP_OKAY     2'h0
`define PSWC_RESP_SLVERR   2'h2

// Read value of the wake-probe register (arbitrary pattern)
`define PSWC_PROBE_VALUE   32'h8765_4321

// Clock rate and times
`define PSWC_CLK_MHZ       200
`define PSWC_READY_MAX_US  2000
`define PSWC_PULSE_MS      50

`endif

// ===== common/pswc_pkg.sv
// Types shared by the power-state controller
package pswc_pkg;

    // Controller states, Gray-coded except PSWC_ST_NORMAL -> PSWC_ST_SLEEP_ED and PSWC_ST_SLEEP_PHY -> PSWC_ST_RESUME
    typedef enum logic [1:0] {
        PSWC_ST_NORMAL   = 2'h0,
        PSWC_ST_SLEEP_PHY = 2'h1,
        PSWC_ST_SLEEP_ED = 2'h3,
        PSWC_ST_RESUME   = 2'h2
    } pswc_state_t;

    // Software-visible control fields
    typedef struct packed {
        logic [1:0] power_state_select;
        logic [1:0] wake_source_status;
        logic       frame_wake_enable;
        logic       energy_wake_enable;
        logic       wake_pulse_select;
        logic       wake_pin_enable;
    } pswc_ctrl_t;

endpackage : pswc_pkg

// ===== rtl/pswc_top.sv
// Power-state and wake controller with its AXI4-Lite register slave
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pswc_cfg.svh"
`default_nettype none

module pswc_top
    import pswc_pkg::*;
#(
    parameter int unsigned ADDR_W        = 8,
    parameter int unsigned RESUME_CYCLES = `PSWC_READY_MAX_US * `PSWC_CLK_MHZ,
    parameter int unsigned PULSE_CYCLES  = `PSWC_PULSE_MS * 1000 * `PSWC_CLK_MHZ
) (
    input  wire logic              SYS_CLK_I,
    input  wire logic              SYS_RST_I,
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
    input  wire logic              S_AXI_AWVALID_I,
    output logic                   S_AXI_AWREADY_O,
    input  wire logic [31:0]       S_AXI_WDATA_I,
    input  wire logic [3:0]        S_AXI_WSTRB_I,
    input  wire logic              S_AXI_WVALID_I,
    output logic                   S_AXI_WREADY_O,
    output logic [1:0]             S_AXI_BRESP_O,
    output logic                   S_AXI_BVALID_O,
    input  wire logic              S_AXI_BREADY_I,
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input  wire logic              S_AXI_ARVALID_I,
    output logic                   S_AXI_ARREADY_O,
    output logic [31:0]            S_AXI_RDATA_O,
    output logic [1:0]             S_AXI_RRESP_O,
    output logic                   S_AXI_RVALID_O,
    input  wire logic              S_AXI_RREADY_I,
    input  wire logic              FRAME_DETECT_I,
    input  wire logic              CARRIER_I,
    output logic                   WAKE_PIN_O,
    output logic                   WAKE_DETECT_EN_O,
    output logic                   MAC_CLK_EN_O,
    output logic                   HOST_CLK_EN_O,
    output logic                   INT_CLK_EN_O,
    output logic                   PHY_ENERGY_POWERDOWN_O
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Expand byte strobes into a bit mask
    function automatic logic [31:0] byte_mask(input logic [3:0] strb);
        return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction : byte_mask

    // True for any of the four mapped word addresses
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
        logic [7:0] a;
        a = addr[7:0];
        return (a == `PSWC_OFF_CTRL) || (a == `PSWC_OFF_PROBE) ||
               (a == `PSWC_OFF_IRQ) || (a == `PSWC_OFF_PHY);
    endfunction : addr_mapped

    ////////////////////////////////////////////////////////////////////////////////
    // State and storage

    pswc_state_t       state;
    pswc_ctrl_t        ctrl;
    logic              seen_read;
    logic              wake_irq;
    logic              phy_edpd;
    logic [31:0]       resume_cnt;
    logic [31:0]       pulse_cnt;
    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              ready;
    logic              wr_fire;
    logic              wr_apply;
    logic              rd_fire;
    logic              frame_hit;
    logic              energy_hit;
    logic              energy_seen;
    logic              pin_cond;
    logic [31:0]       ctrl_word;
    logic [31:0]       wmask;
    logic [31:0]       ctrl_merged;
    logic [1:0]        next_pss;

    // Ready only in the normal state; sleep entry clears it
    assign ready = (state == PSWC_ST_NORMAL);

    // Control register image
    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[`PSWC_BIT_READY]   = ready;
        ctrl_word[`PSWC_BIT_PIN_EN]  = ctrl.wake_pin_enable;
        ctrl_word[`PSWC_BIT_PULSE]   = ctrl.wake_pulse_select;
        ctrl_word[`PSWC_BIT_ENERGY]  = ctrl.energy_wake_enable;
        ctrl_word[`PSWC_BIT_FRAME]   = ctrl.frame_wake_enable;
        ctrl_word[`PSWC_BIT_WSS+:2]  = ctrl.wake_source_status;
        ctrl_word[`PSWC_BIT_PSS+:2]  = ctrl.power_state_select;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path

    // Address and data are taken in either order and held until both are in
    assign S_AXI_AWREADY_O = !aw_held;
    assign S_AXI_WREADY_O  = !w_held;
    assign wr_fire  = aw_held && w_held && !S_AXI_BVALID_O;
    // Writes need a prior read, and ready unless aimed at the wake probe
    assign wr_apply = wr_fire && seen_read &&
                      (ready || aw_addr[7:0] == `PSWC_OFF_PROBE);
    assign wmask       = byte_mask(w_strb);
    assign ctrl_merged = (ctrl_word & ~wmask) | (w_data & wmask);
    assign next_pss    = ctrl_merged[`PSWC_BIT_PSS+:2];

    // Hold the write address
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (S_AXI_AWVALID_I && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR_I;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    // Hold the write data
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (S_AXI_WVALID_I && !w_held) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA_I;
            w_strb <= S_AXI_WSTRB_I;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // Write answer: refused or unmapped writes answer SLVERR
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O  <= `PSWC_RESP_OKAY;
        end else if (wr_fire) begin
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O  <= (wr_apply && addr_mapped(aw_addr)) ?
                              `PSWC_RESP_OKAY : `PSWC_RESP_SLVERR;
        end else if (S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path

    assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
    assign rd_fire = S_AXI_ARVALID_I && S_AXI_ARREADY_O;

    // Read answer one cycle after the address; sleep blocks all but control
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O  <= 32'h0000_0000;
            S_AXI_RRESP_O  <= `PSWC_RESP_OKAY;
        end else if (rd_fire) begin
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RRESP_O  <= `PSWC_RESP_OKAY;
            S_AXI_RDATA_O  <= 32'h0000_0000;
            if (!ready && S_AXI_ARADDR_I[7:0] != `PSWC_OFF_CTRL) begin
                S_AXI_RRESP_O <= `PSWC_RESP_SLVERR;
            end else begin
                unique case (S_AXI_ARADDR_I[7:0])
                    `PSWC_OFF_CTRL:  S_AXI_RDATA_O <= ctrl_word;
                    `PSWC_OFF_PROBE: S_AXI_RDATA_O <= `PSWC_PROBE_VALUE;
                    `PSWC_OFF_IRQ:   S_AXI_RDATA_O[`PSWC_BIT_IRQ_WAKE] <= wake_irq;
                    `PSWC_OFF_PHY:   S_AXI_RDATA_O[`PSWC_BIT_PHY_EDPD] <= phy_edpd;
                    default:         S_AXI_RRESP_O <= `PSWC_RESP_SLVERR;
                endcase
            end
        end else if (S_AXI_RREADY_I) begin
            S_AXI_RVALID_O <= 1'b0;
        end
    end

    // Read seen since reset or wake; a read in the wake cycle wins
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            seen_read <= 1'b0;
        end else if (rd_fire) begin
            seen_read <= 1'b1;
        end else if (wr_apply && aw_addr[7:0] == `PSWC_OFF_PROBE && !ready) begin
            seen_read <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power-state machine

    // Sleep entry by select write, wake by probe write, ready after resume delay
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            state <= PSWC_ST_NORMAL;
        end else begin
            unique case (state)
                PSWC_ST_NORMAL: begin
                    if (wr_apply && aw_addr[7:0] == `PSWC_OFF_CTRL &&
                        next_pss == `PSWC_PSS_SLEEP1) begin
                        state <= PSWC_ST_SLEEP_PHY;
                    end else if (wr_apply && aw_addr[7:0] == `PSWC_OFF_CTRL &&
                                 next_pss == `PSWC_PSS_SLEEP2) begin
                        state <= PSWC_ST_SLEEP_ED;
                    end
                end
                PSWC_ST_SLEEP_PHY, PSWC_ST_SLEEP_ED: begin
                    if (wr_apply && aw_addr[7:0] == `PSWC_OFF_PROBE) begin
                        state <= PSWC_ST_RESUME;
                    end
                end
                PSWC_ST_RESUME: begin
                    if (resume_cnt >= RESUME_CYCLES - 1) begin
                        state <= PSWC_ST_NORMAL;
                    end
                end
            endcase
        end
    end

    // Cycles spent resuming
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I || state != PSWC_ST_RESUME) begin
            resume_cnt <= 32'h0000_0000;
        end else begin
            resume_cnt <= resume_cnt + 32'h0000_0001;
        end
    end

    // Clock enables follow the state
    assign HOST_CLK_EN_O    = (state == PSWC_ST_NORMAL);
    assign MAC_CLK_EN_O     = (state == PSWC_ST_NORMAL);
    assign INT_CLK_EN_O     = (state != PSWC_ST_SLEEP_ED);
    assign WAKE_DETECT_EN_O = (state == PSWC_ST_SLEEP_PHY);

    ////////////////////////////////////////////////////////////////////////////////
    // Wake detection

    assign frame_hit  = (state == PSWC_ST_SLEEP_PHY) && FRAME_DETECT_I;
    // Level detection catches a carrier already present at entry
    assign energy_hit = (state == PSWC_ST_SLEEP_ED) && CARRIER_I && !energy_seen;

    // One carrier event per energy-detect sleep, so a stale status cannot hide it
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I || state != PSWC_ST_SLEEP_ED) begin
            energy_seen <= 1'b0;
        end else if (CARRIER_I) begin
            energy_seen <= 1'b1;
        end
    end

    // Control fields; state persists across sleep, detection beats clear
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            ctrl <= '0;
        end else begin
            if (wr_apply && aw_addr[7:0] == `PSWC_OFF_CTRL && ready) begin
                ctrl.wake_pin_enable    <= ctrl_merged[`PSWC_BIT_PIN_EN];
                ctrl.wake_pulse_select  <= ctrl_merged[`PSWC_BIT_PULSE];
                ctrl.energy_wake_enable <= ctrl_merged[`PSWC_BIT_ENERGY];
                ctrl.frame_wake_enable  <= ctrl_merged[`PSWC_BIT_FRAME];
                if (next_pss == `PSWC_PSS_SLEEP1 || next_pss == `PSWC_PSS_SLEEP2) begin
                    ctrl.power_state_select <= next_pss;
                end
            end
            if (wr_apply && aw_addr[7:0] == `PSWC_OFF_PROBE && !ready) begin
                ctrl.power_state_select <= `PSWC_PSS_NORMAL;
            end
            if (frame_hit) begin
                ctrl.wake_source_status <= `PSWC_WSS_FRAME;
            end else if (energy_hit) begin
                ctrl.wake_source_status <= `PSWC_WSS_ENERGY;
            end else if (wr_apply && aw_addr[7:0] == `PSWC_OFF_CTRL) begin
                ctrl.wake_source_status <= ctrl.wake_source_status &
                                           ~(w_data[`PSWC_BIT_WSS+:2] & wmask[`PSWC_BIT_WSS+:2]);
            end
        end
    end

    // Sticky wake flag, write one to clear, set wins
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            wake_irq <= 1'b0;
        end else if (frame_hit || energy_hit) begin
            wake_irq <= 1'b1;
        end else if (wr_apply && aw_addr[7:0] == `PSWC_OFF_IRQ &&
                     w_data[`PSWC_BIT_IRQ_WAKE] && w_strb[0]) begin
            wake_irq <= 1'b0;
        end
    end

    // Energy-detect power-down bit, kept through sleep
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            phy_edpd <= 1'b0;
        end else if (wr_apply && aw_addr[7:0] == `PSWC_OFF_PHY && w_strb[0]) begin
            phy_edpd <= w_data[`PSWC_BIT_PHY_EDPD];
        end
    end
    assign PHY_ENERGY_POWERDOWN_O = phy_edpd;

    ////////////////////////////////////////////////////////////////////////////////
    // Wake pin

    // Source status matched by its enable, all behind the pin enable
    assign pin_cond = ctrl.wake_pin_enable &&
        ((ctrl.wake_source_status == `PSWC_WSS_FRAME && ctrl.frame_wake_enable) ||
         (ctrl.wake_source_status == `PSWC_WSS_ENERGY && ctrl.energy_wake_enable));

    // Pulse length timer, loaded on every wake event
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            pulse_cnt <= 32'h0000_0000;
        end else if (frame_hit || energy_hit) begin
            pulse_cnt <= PULSE_CYCLES;
        end else if (pulse_cnt != 32'h0000_0000) begin
            pulse_cnt <= pulse_cnt - 32'h0000_0001;
        end
    end

    // Pulsed or steady drive of the pin
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            WAKE_PIN_O <= 1'b0;
        end else begin
            WAKE_PIN_O <= pin_cond &&
                          (!ctrl.wake_pulse_select || pulse_cnt != 32'h0000_0000);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    logic [31:0] resume_age;
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I || state != PSWC_ST_RESUME) begin
            resume_age <= 32'h0000_0000;
        end else begin
            resume_age <= resume_age + 32'h0000_0001;
        end
    end

    sequence seq_probe_in_sleep;
        wr_fire && seen_read && aw_addr[7:0] == `PSWC_OFF_PROBE &&
        (state == PSWC_ST_SLEEP_PHY || state == PSWC_ST_SLEEP_ED);
    endsequence
    sequence seq_resumed;
        state == PSWC_ST_RESUME && ctrl.power_state_select == `PSWC_PSS_NORMAL;
    endsequence

    chk_sleep_read_gate: assert property (rd_fire && !ready &&
        S_AXI_ARADDR_I[7:0] != `PSWC_OFF_CTRL |=> S_AXI_RVALID_O &&
        S_AXI_RRESP_O == `PSWC_RESP_SLVERR && S_AXI_RDATA_O == 32'h0000_0000)
        else $error("blocked read answered without error");
    chk_write_needs_read: assert property (wr_fire && !seen_read |=>
        $stable(ctrl.power_state_select) && $stable(phy_edpd) && state == $past(state))
        else $error("write took effect before any read");
    chk_probe_wakes: assert property (seq_probe_in_sleep |=> seq_resumed)
        else $error("wake-probe write did not wake");
    chk_enter_phy_sleep: assert property (wr_apply && ready &&
        aw_addr[7:0] == `PSWC_OFF_CTRL && next_pss == `PSWC_PSS_SLEEP1 |=>
        state == PSWC_ST_SLEEP_PHY && !ctrl_word[`PSWC_BIT_READY])
        else $error("sleep select 01 not honoured");
    chk_frame_status: assert property (frame_hit |=>
        ctrl.wake_source_status == `PSWC_WSS_FRAME && wake_irq)
        else $error("frame wake not recorded");
    chk_carrier_status: assert property (state == PSWC_ST_SLEEP_ED && CARRIER_I |=>
        ctrl.wake_source_status == `PSWC_WSS_ENERGY && wake_irq)
        else $error("carrier wake not recorded");
    chk_ready_bound: assert property (state == PSWC_ST_RESUME |-> resume_age < RESUME_CYCLES)
        else $error("ready late after wake");
    chk_pin_release: assert property (!ctrl.wake_pin_enable ||
        ctrl.wake_source_status == `PSWC_WSS_NONE |=> !WAKE_PIN_O)
        else $error("wake pin active without cause");
    chk_clock_gates: assert property (state == PSWC_ST_SLEEP_ED |->
        !INT_CLK_EN_O && !MAC_CLK_EN_O && !HOST_CLK_EN_O && !WAKE_DETECT_EN_O)
        else $error("clocks running in energy-detect sleep");

endmodule : pswc_top

`default_nettype wire

// ===== verification/pswc_host.sv
// Host model: AXI4-Lite master with one write and one read under way
`timescale 1ns/1ps
`default_nettype none
module pswc_host (
    input  wire logic        clk_i,
    output logic [7:0]       aw_o,
    output logic             awv_o,
    input  wire logic        awr_i,
    output logic [31:0]      wd_o,
    output logic             wv_o,
    input  wire logic        wr_i,
    input  wire logic [1:0]  br_i,
    input  wire logic        bv_i,
    output logic             bre_o,
    output logic [7:0]       ar_o,
    output logic             arv_o,
    input  wire logic        arr_i,
    input  wire logic [31:0] rd_i,
    input  wire logic [1:0]  rr_i,
    input  wire logic        rv_i,
    output logic             rre_o
);
    // Idle bus from time zero
    initial begin
        {awv_o, wv_o, bre_o, arv_o, rre_o} = 5'h0;
        {aw_o, wd_o, ar_o} = 48'h0;
    end
    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge clk_i);
        aw_o  <= a;
        wd_o  <= d;
        awv_o <= 1'b1;
        wv_o  <= 1'b1;
        bre_o <= 1'b1;
        do begin
            @(negedge clk_i);
            ta = awv_o & awr_i;
            tw = wv_o & wr_i;
            tb = bv_i;
            r  = br_i;
            @(posedge clk_i);
            if (ta) awv_o <= 1'b0;
            if (tw) wv_o <= 1'b0;
        end while (tb !== 1'b1);
        bre_o <= 1'b0;
    endtask : wr
    // Read: held until taken, answer kept at the rready edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic tr, tb;
        @(posedge clk_i);
        ar_o  <= a;
        arv_o <= 1'b1;
        rre_o <= 1'b1;
        do begin
            @(negedge clk_i);
            tr = arv_o & arr_i;
            tb = rv_i;
            d  = rd_i;
            r  = rr_i;
            @(posedge clk_i);
            if (tr) arv_o <= 1'b0;
        end while (tb !== 1'b1);
        rre_o <= 1'b0;
    endtask : rd
endmodule : pswc_host
`default_nettype wire

// ===== verification/test_power_state_wake_control.sv
// Self-checking bench of the power-state controller against a field model
`timescale 1ns/1ps
`include "pswc_cfg.svh"
`default_nettype none
module test_power_state_wake_control;
    localparam int RES = 8;
    localparam int PUL = 16;
    logic        clk, rst, awv, wv, bre, arv, rre, awr, wrd, bv, arr, rv;
    logic        fd, car, pin, wde, mce, hce, ice, pepd;
    logic [7:0]  aw, ar;
    logic [31:0] wd, rdat, rdo;
    logic [1:0]  brs, rrs, resp;
    int          err_total = 0, samples_checked = 0, pin_cnt = 0;
    int          m_pss = 0, m_wss = 0, m_en = 0;
    logic        m_rdy = 1'b1;

    pswc_top #(.RESUME_CYCLES(RES), .PULSE_CYCLES(PUL)) pswc_top_inst (
        .SYS_CLK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(aw), .S_AXI_AWVALID_I(awv),
        .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv),
        .S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(brs), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre),
        .S_AXI_ARADDR_I(ar), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
        .S_AXI_RDATA_O(rdo), .S_AXI_RRESP_O(rrs), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre),
        .FRAME_DETECT_I(fd), .CARRIER_I(car), .WAKE_PIN_O(pin), .WAKE_DETECT_EN_O(wde),
        .MAC_CLK_EN_O(mce), .HOST_CLK_EN_O(hce), .INT_CLK_EN_O(ice),
        .PHY_ENERGY_POWERDOWN_O(pepd));
    pswc_host pswc_host_inst (.clk_i(clk), .aw_o(aw), .awv_o(awv), .awr_i(awr), .wd_o(wd),
        .wv_o(wv), .wr_i(wrd), .br_i(brs), .bv_i(bv), .bre_o(bre), .ar_o(ar), .arv_o(arv),
        .arr_i(arr), .rd_i(rdo), .rr_i(rrs), .rv_i(rv), .rre_o(rre));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and wake pin high-time counter
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (pin === 1'b1) pin_cnt <= pin_cnt + 1;
    end
    // Model view of the control register
    function automatic logic [31:0] ctrl_exp();
        return 32'((m_pss << 16) | (m_wss << 12) | m_en | int'(m_rdy));
    endfunction : ctrl_exp
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        pswc_host_inst.wr(a, d, resp);
        chk("bresp", 32'(resp), 32'(e));
    endtask : wrc
    task automatic rdc(input logic [7:0] a, input logic [1:0] e, input logic [31:0] v);
        pswc_host_inst.rd(a, rdat, resp);
        chk("rresp", 32'(resp), 32'(e));
        chk("rdata", rdat, v);
    endtask : rdc
    // Pin and clock-enable outputs: pin, detect, mac, host, internal, powerdown
    task automatic pins(input logic [5:0] e);
        @(negedge clk);
        chk("pins", 32'({pin, wde, mce, hce, ice, pepd}), 32'(e));
    endtask : pins
    // Poll the control register for ready, bounded
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            pswc_host_inst.rd(`PSWC_OFF_CTRL, rdat, resp);
            n++;
        end while (rdat[0] !== 1'b1 && n < 20);
        chk("ctrl", rdat, ctrl_exp());
    endtask : wait_rdy
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst, fd, car} = 3'h4;
        void'($urandom(40));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        pins(6'h0E);
        wrc(`PSWC_OFF_CTRL, 32'h0000_0302, `PSWC_RESP_SLVERR);
        rdc(`PSWC_OFF_CTRL, `PSWC_RESP_OKAY, ctrl_exp());
        wrc(`PSWC_OFF_CTRL, 32'h0003_0302, `PSWC_RESP_OKAY);
        m_en = 32'h0000_0302;
        rdc(`PSWC_OFF_CTRL, `PSWC_RESP_OKAY, ctrl_exp());
        rdc(`PSWC_OFF_PROBE, `PSWC_RESP_OKAY, `PSWC_PROBE_VALUE);
        rdc(8'h10, `PSWC_RESP_SLVERR, 32'h0000_0000);
        wrc(`PSWC_OFF_CTRL, 32'h0001_0302, `PSWC_RESP_OKAY);
        m_pss = 1;
        m_rdy = 1'b0;
        rdc(`PSWC_OFF_CTRL, `PSWC_RESP_OKAY, ctrl_exp());
        rdc(`PSWC_OFF_IRQ, `PSWC_RESP_SLVERR, 32'h0000_0000);
        pins(6'h12);
        @(posedge clk);
        fd <= 1'b1;
        @(posedge clk);
        fd <= 1'b0;
        m_wss = 2;
        repeat (3) @(posedge clk);
        pins(6'h32);
        rdc(`PSWC_OFF_CTRL, `PSWC_RESP_OKAY, ctrl_exp());
        wrc(`PSWC_OFF_PROBE, $urandom, `PSWC_RESP_OKAY);
        m_pss = 0;
        m_rdy = 1'b1;
        wait_rdy();
        rdc(`PSWC_OFF_IRQ, `PSWC_RESP_OKAY, 32'h0000_0001);
        wrc(`PSWC_OFF_CTRL, 32'h0000_3302, `PSWC_RESP_OKAY);
        m_wss = 0;
        repeat (2) @(posedge clk);
        pins(6'h0E);
        wrc(`PSWC_OFF_IRQ, 32'h0000_0001, `PSWC_RESP_OKAY);
        rdc(`PSWC_OFF_IRQ, `PSWC_RESP_OKAY, 32'h0000_0000);
        wrc(`PSWC_OFF_PHY, 32'h0000_0001, `PSWC_RESP_OKAY);
        wrc(`PSWC_OFF_CTRL, 32'h0000_0306, `PSWC_RESP_OKAY);
        m_en = 32'h0000_0306;
        car <= 1'b1;
        pin_cnt = 0;
        wrc(`PSWC_OFF_CTRL, 32'h0002_0306, `PSWC_RESP_OKAY);
        m_pss = 2;
        m_rdy = 1'b0;
        m_wss = 1;
        repeat (40) @(posedge clk);
        pins(6'h01);
        chk("pulse", 32'(pin_cnt inside {[PUL-2:PUL]}), 32'h0000_0001);
        rdc(`PSWC_OFF_CTRL, `PSWC_RESP_OKAY, ctrl_exp());
        car <= 1'b0;
        wrc(`PSWC_OFF_PROBE, $urandom, `PSWC_RESP_OKAY);
        m_pss = 0;
        m_rdy = 1'b1;
        wait_rdy();
        wrc(`PSWC_OFF_PHY, 32'h0000_0000, `PSWC_RESP_OKAY);
        wrc(`PSWC_OFF_CTRL, 32'h0000_3306, `PSWC_RESP_OKAY);
        m_wss = 0;
        pins(6'h0E);
        rdc(`PSWC_OFF_CTRL, `PSWC_RESP_OKAY, ctrl_exp());
        close_out();
    end
    // Watchdog against a hung handshake
    initial begin
        #50000;
        err_total++;
        close_out();
    end
endmodule : test_power_state_wake_control
`default_nettype wire
